// *** awos_defines.vh ***
`ifndef AWOS_DEFINES_VH
`define AWOS_DEFINES_VH

// Register word indices and byte offsets
`define AWOS_ADR_WAVE     3'h0
`define AWOS_ADR_AMP      3'h1
`define AWOS_ADR_OFS      3'h2
`define AWOS_ADR_PER      3'h3
`define AWOS_ADR_CTRL     3'h4
`define AWOS_ADR_STAT     3'h5
`define AWOS_ADR_OUT      3'h6
`define AWOS_OFF_WAVE     5'h00
`define AWOS_OFF_AMP      5'h04
`define AWOS_OFF_OFS      5'h08
`define AWOS_OFF_PER      5'h0c
`define AWOS_OFF_CTRL     5'h10
`define AWOS_OFF_STAT     5'h14
`define AWOS_OFF_OUT      5'h18

// Field widths and positions
`define AWOS_CODE_W       12
`define AWOS_PER_W        11
`define AWOS_WAVE_W       3
`define AWOS_CTRL_GO      0
`define AWOS_STAT_ACT     0
`define AWOS_STAT_WAVE_LO 4
`define AWOS_STAT_STEP_LO 8
`define AWOS_OUT_OFS_LO   16

// Waveform selector codes
`define AWOS_WAVE_OFF     3'h0
`define AWOS_WAVE_DC      3'h1
`define AWOS_WAVE_UP      3'h2
`define AWOS_WAVE_DOWN    3'h3
`define AWOS_WAVE_TRI     3'h4
`define AWOS_WAVE_SQR     3'h5
`define AWOS_WAVE_SINE    3'h6

// Steps per period, as shift counts
`define AWOS_SHIFT_32     3'h5
`define AWOS_SHIFT_2      3'h1
`define AWOS_STEP_LAST    5'h1f
`define AWOS_STEP_HALF    5'h10
`define AWOS_FRAC_FULL    6'h20

// Period limits in milliseconds
`define AWOS_PER_MIN      11'h005
`define AWOS_PER_MAX      11'h7d0

// Sine peak in amplitude counts, table scale shift
`define AWOS_SINE_PEAK    12'h600
`define AWOS_SINE_TSHIFT  7
`define AWOS_SINE_MAXHALF 12'h00f

// Reset values
`define AWOS_RST_CODE     12'h000
`define AWOS_RST_PER      11'h005
`define AWOS_RST_WAVE     3'h0

// Timing: 1 ms tick from a 10 ns clock
`define AWOS_TICK_NS      1000000
`define AWOS_CLK_NS       10

`endif

// *** awos_step_timer.v ***
`timescale 1ns/100ps
`default_nettype none

module awos_step_timer #(
	parameter CNT_W = 28
) (
	// System
	input  wire             clk_i,
	input  wire             rst_i,
	// Control
	input  wire             en_i,
	input  wire             restart_i,
	input  wire [CNT_W-1:0] len_i,
	// Step strobe
	output wire             step_o
);

	reg  [CNT_W-1:0] cnt_reg;
	wire [CNT_W-1:0] cnt_inc;
	wire             last;

	assign cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
	// Zero length behaves as one cycle
	assign last    = (cnt_inc >= len_i);
	assign step_o  = en_i & ~restart_i & last;

	always @(posedge clk_i) begin
		if (rst_i | restart_i | ~en_i) begin
			cnt_reg <= {CNT_W{1'b0}};
		end else if (last) begin
			cnt_reg <= {CNT_W{1'b0}};
		end else begin
			cnt_reg <= cnt_inc;
		end
	end

endmodule

`default_nettype wire

// *** awos_sequencer.v ***
// Behaviour
// - Selector codes: 0 off, 1 DC, 2 ramp up, 3 ramp down, 4 triangle, 5 square, 6 sine.
// - Amplitude is unsigned 0..4095 wave height; sine mode reads it differently.
// - Offset is unsigned 0..4095 and sets the level the wave centres on.
// - Period is whole milliseconds, 5 through 2000, the waveform repeat interval.
// - Output level is 0.0024 V per amplitude count minus 0.0012 V per offset count.
// - An accepted setup drives the output at once, whatever waveform runs.
// - Output stays on until reset or an off command; reset turns it off.
// - All waveforms but DC are discrete steps repeating every period.
// - Square wave uses two levels per period.
// - Triangle uses 32 steps: sixteen rising then sixteen falling.
// - Ramp up, ramp down and sine each use 32 steps per period.
// - Sine peak defaults to 1536 counts (about 3.69 V); amplitude gives how often it is halved.
// - A setup command returns no data; its only effect is the output.
`timescale 1ns/100ps
`default_nettype none
`include "awos_defines.vh"

module awos_sequencer #(
	parameter MS_CYCLES = `AWOS_TICK_NS / `AWOS_CLK_NS
) (
	// System
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [4:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	// Converter pair
	output wire [11:0] dac_amp_o,
	output wire [11:0] dac_ofs_o,
	output wire        dac_en_o,
	output wire        dac_load_o
);

	localparam CNT_W   = 28;
	localparam PROD_W  = 40;
	localparam ST_OFF  = 3'b001;
	localparam ST_DC   = 3'b010;
	localparam ST_RUN  = 3'b100;

	// Amplitude scaled by a fraction of 32
	function [11:0] scale;
		input [11:0] a;
		input [5:0]  f;
		reg   [17:0] p;
		begin
			p     = a * f;
			scale = p[16:5];
		end
	endfunction

	// Quarter sine, 0..8 of 32 steps, full scale 127
	function [7:0] qsine;
		input [3:0] k;
		begin
			case (k)
				4'h0:    qsine = 8'h00;
				4'h1:    qsine = 8'h19;
				4'h2:    qsine = 8'h31;
				4'h3:    qsine = 8'h47;
				4'h4:    qsine = 8'h5a;
				4'h5:    qsine = 8'h6a;
				4'h6:    qsine = 8'h75;
				4'h7:    qsine = 8'h7d;
				default: qsine = 8'h7f;
			endcase
		end
	endfunction

	// Clamp a signed sum into converter range
	function [11:0] clip;
		input signed [23:0] v;
		begin
			if (v < 0) begin
				clip = 12'h000;
			end else if (v > 24'sh000fff) begin
				clip = 12'hfff;
			end else begin
				clip = v[11:0];
			end
		end
	endfunction

	// Staging fields written by software
	reg  [2:0]        st_wave_reg;
	reg  [11:0]       st_amp_reg;
	reg  [11:0]       st_ofs_reg;
	reg  [10:0]       st_per_reg;
	// Active setup
	reg  [2:0]        wave_reg;
	reg  [11:0]       amp_reg;
	reg  [11:0]       ofs_reg;
	reg  [CNT_W-1:0]  len_reg;
	reg  [2:0]        state_reg;
	reg  [2:0]        state_next;
	reg  [4:0]        step_reg;
	reg               restart_reg;
	reg               step_d_reg;
	// Converter outputs
	reg  [11:0]       dac_amp_reg;
	reg  [11:0]       dac_ofs_reg;
	reg               dac_load_reg;
	reg  [11:0]       amp_next;
	// Bus
	reg               ack_reg;
	reg  [31:0]       dat_reg;
	reg  [31:0]       rd_data;

	wire              bus_req;
	wire              wr_en;
	wire              go;
	wire              step_tick;
	wire [10:0]       per_clamped;
	wire [PROD_W-1:0] per_cycles;
	wire [2:0]        step_shift;
	wire [5:0]        frac_up;
	wire [5:0]        frac_down;
	wire [5:0]        frac_tri;
	wire [3:0]        sine_k;
	wire [7:0]        sine_mag;
	wire signed [23:0] sine_swing;
	wire signed [23:0] sine_scaled;
	wire signed [23:0] sine_sum;
	wire [3:0]        halvings;

	// Wishbone classic: answer one cycle after the request
	assign bus_req = cyc_i & stb_i;
	assign wr_en   = bus_req & we_i & ack_reg;
	assign ack_o   = ack_reg;
	assign dat_o   = dat_reg;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			dat_reg <= rd_data;
		end
	end

	// Read mux; no data is produced by a setup itself
	always @* begin
		rd_data = 32'h0000_0000;
		case (adr_i[4:2])
			`AWOS_ADR_WAVE: rd_data[`AWOS_WAVE_W-1:0] = st_wave_reg;
			`AWOS_ADR_AMP:  rd_data[`AWOS_CODE_W-1:0] = st_amp_reg;
			`AWOS_ADR_OFS:  rd_data[`AWOS_CODE_W-1:0] = st_ofs_reg;
			`AWOS_ADR_PER:  rd_data[`AWOS_PER_W-1:0]  = st_per_reg;
			`AWOS_ADR_STAT: begin
				rd_data[`AWOS_STAT_ACT]                            = dac_en_o;
				rd_data[`AWOS_STAT_WAVE_LO +: `AWOS_WAVE_W]        = wave_reg;
				rd_data[`AWOS_STAT_STEP_LO +: 5]                   = step_reg;
			end
			`AWOS_ADR_OUT: begin
				rd_data[`AWOS_CODE_W-1:0]                          = dac_amp_reg;
				rd_data[`AWOS_OUT_OFS_LO +: `AWOS_CODE_W]          = dac_ofs_reg;
			end
			default:        rd_data = 32'h0000_0000;
		endcase
	end

	// Staging writes, byte lanes honoured
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_wave_reg <= `AWOS_RST_WAVE;
			st_amp_reg  <= `AWOS_RST_CODE;
			st_ofs_reg  <= `AWOS_RST_CODE;
			st_per_reg  <= `AWOS_RST_PER;
		end else if (wr_en) begin
			case (adr_i[4:2])
				`AWOS_ADR_WAVE: begin
					if (sel_i[0]) st_wave_reg <= dat_i[2:0];
				end
				`AWOS_ADR_AMP: begin
					if (sel_i[0]) st_amp_reg[7:0]  <= dat_i[7:0];
					if (sel_i[1]) st_amp_reg[11:8] <= dat_i[11:8];
				end
				`AWOS_ADR_OFS: begin
					if (sel_i[0]) st_ofs_reg[7:0]  <= dat_i[7:0];
					if (sel_i[1]) st_ofs_reg[11:8] <= dat_i[11:8];
				end
				`AWOS_ADR_PER: begin
					if (sel_i[0]) st_per_reg[7:0]  <= dat_i[7:0];
					if (sel_i[1]) st_per_reg[10:8] <= dat_i[10:8];
				end
				default: begin
				end
			endcase
		end
	end

	assign go = wr_en & sel_i[0] & (adr_i[4:2] == `AWOS_ADR_CTRL) & dat_i[`AWOS_CTRL_GO];

	// Period held inside 5..2000 ms
	assign per_clamped = (st_per_reg < `AWOS_PER_MIN) ? `AWOS_PER_MIN :
	                     (st_per_reg > `AWOS_PER_MAX) ? `AWOS_PER_MAX : st_per_reg;

	// Step length: millisecond period in cycles over steps per period
	assign step_shift = (st_wave_reg == `AWOS_WAVE_SQR) ? `AWOS_SHIFT_2 : `AWOS_SHIFT_32;
	assign per_cycles = per_clamped * MS_CYCLES;

	// Mode state
	always @* begin
		state_next = state_reg;
		if (go) begin
			case (st_wave_reg)
				`AWOS_WAVE_OFF:  state_next = ST_OFF;
				`AWOS_WAVE_DC:   state_next = ST_DC;
				`AWOS_WAVE_UP,
				`AWOS_WAVE_DOWN,
				`AWOS_WAVE_TRI,
				`AWOS_WAVE_SQR,
				`AWOS_WAVE_SINE: state_next = ST_RUN;
				default:         state_next = ST_OFF;
			endcase
		end
	end

	// Commit takes the whole four-field setup at once
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg   <= ST_OFF;
			wave_reg    <= `AWOS_RST_WAVE;
			amp_reg     <= `AWOS_RST_CODE;
			ofs_reg     <= `AWOS_RST_CODE;
			len_reg     <= {CNT_W{1'b0}};
			restart_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			restart_reg <= go;
			if (go) begin
				wave_reg <= st_wave_reg;
				amp_reg  <= st_amp_reg;
				ofs_reg  <= st_ofs_reg;
				len_reg  <= per_cycles[CNT_W-1:0] >> step_shift;
			end
		end
	end

	awos_step_timer #(
		.CNT_W     (CNT_W)
	) u_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.en_i      (state_reg == ST_RUN),
		.restart_i (go),
		.len_i     (len_reg),
		.step_o    (step_tick)
	);

	// Step index wraps each period
	always @(posedge clk_i) begin
		if (rst_i | go) begin
			step_reg <= 5'h00;
		end else if (step_tick) begin
			if (wave_reg == `AWOS_WAVE_SQR) begin
				step_reg <= {4'h0, ~step_reg[0]};
			end else begin
				step_reg <= step_reg + 5'h01;
			end
		end
	end

	// Load pulse trails the index so codes and strobe line up
	always @(posedge clk_i) begin
		if (rst_i) begin
			step_d_reg <= 1'b0;
		end else begin
			step_d_reg <= step_tick;
		end
	end

	// Fractions of amplitude per step
	assign frac_up   = {1'b0, step_reg} + 6'h01;
	assign frac_down = `AWOS_FRAC_FULL - {1'b0, step_reg};
	assign frac_tri  = (step_reg < `AWOS_STEP_HALF) ? {step_reg[3:0], 1'b0} + 6'h02 :
	                   {(`AWOS_STEP_LAST - step_reg), 1'b0} - 6'h00;

	// Sine: fixed peak, halved by the amplitude count
	assign sine_k      = (step_reg[3:0] > 4'h8) ? (4'h0 - step_reg[3:0]) : step_reg[3:0];
	assign sine_mag    = qsine(sine_k);
	assign halvings    = (amp_reg > `AWOS_SINE_MAXHALF) ? 4'hf : amp_reg[3:0];
	assign sine_swing  = $signed({16'h0000, sine_mag}) * $signed({12'h000, `AWOS_SINE_PEAK});
	assign sine_scaled = (sine_swing >>> `AWOS_SINE_TSHIFT) >>> halvings;
	assign sine_sum    = step_reg[4] ? ($signed({13'h0000, ofs_reg[11:1]}) - sine_scaled) :
	                     ($signed({13'h0000, ofs_reg[11:1]}) + sine_scaled);

	// Amplitude code per waveform
	always @* begin
		amp_next = `AWOS_RST_CODE;
		case (wave_reg)
			`AWOS_WAVE_DC:   amp_next = amp_reg;
			`AWOS_WAVE_UP:   amp_next = scale(amp_reg, frac_up);
			`AWOS_WAVE_DOWN: amp_next = scale(amp_reg, frac_down);
			`AWOS_WAVE_TRI:  amp_next = scale(amp_reg, frac_tri);
			`AWOS_WAVE_SQR:  amp_next = step_reg[0] ? `AWOS_RST_CODE : amp_reg;
			`AWOS_WAVE_SINE: amp_next = clip(sine_sum);
			default:         amp_next = `AWOS_RST_CODE;
		endcase
	end

	// Converter drive: level = 2.4 mV per amplitude count less 1.2 mV per offset count
	always @(posedge clk_i) begin
		if (rst_i) begin
			dac_amp_reg  <= `AWOS_RST_CODE;
			dac_ofs_reg  <= `AWOS_RST_CODE;
			dac_load_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_OFF: begin
					dac_amp_reg  <= `AWOS_RST_CODE;
					dac_ofs_reg  <= `AWOS_RST_CODE;
					dac_load_reg <= restart_reg;
				end
				ST_DC: begin
					dac_amp_reg  <= amp_next;
					dac_ofs_reg  <= ofs_reg;
					dac_load_reg <= restart_reg;
				end
				ST_RUN: begin
					dac_amp_reg  <= amp_next;
					dac_ofs_reg  <= ofs_reg;
					dac_load_reg <= restart_reg | step_d_reg;
				end
				default: begin
					dac_amp_reg  <= `AWOS_RST_CODE;
					dac_ofs_reg  <= `AWOS_RST_CODE;
					dac_load_reg <= 1'b0;
				end
			endcase
		end
	end

	// Enabled from the cycle after commit until off or reset
	assign dac_en_o   = (state_reg != ST_OFF);
	assign dac_amp_o  = dac_amp_reg;
	assign dac_ofs_o  = dac_ofs_reg;
	assign dac_load_o = dac_load_reg;

endmodule

`default_nettype wire

// *** awos_chk_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module awos_chk #(
	parameter MS_CYCLES = 64
) (
	// System
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [4:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// Converters
	input wire logic [11:0] dac_amp_o,
	input wire logic [11:0] dac_ofs_o,
	input wire logic        dac_en_o,
	input wire logic        dac_load_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reg  [2:0]  wv_s;
	reg  [2:0]  wv;
	reg  [10:0] per_s;
	reg  [10:0] per_c;
	reg         cmt_d;
	reg         arm;
	reg  [15:0] gap;
	wire        wr  = cyc_i & stb_i & we_i & ack_o;
	wire        cmt = wr & (adr_i[4:2] == 3'h4) & dat_i[0];
	wire [10:0] pc  = per_c < 11'h005 ? 11'h005 : (per_c > 11'h7d0 ? 11'h7d0 : per_c);
	wire [31:0] len = (wv == 3'h5) ? pc * MS_CYCLES / 2 : pc * MS_CYCLES / 32;
	// Shadow of the committed setup
	always @(posedge clk_i) begin
		if (rst_i) begin
			wv_s <= 3'h0;
			wv <= 3'h0;
			per_s <= 11'h005;
			per_c <= 11'h005;
			cmt_d <= 1'b0;
			arm <= 1'b0;
			gap <= 16'h0000;
		end else begin
			if (wr && adr_i[4:2] == 3'h0)
				wv_s <= dat_i[2:0];
			if (wr && adr_i[4:2] == 3'h3)
				per_s <= dat_i[10:0];
			if (cmt) begin
				wv <= wv_s;
				per_c <= per_s;
			end
			cmt_d <= cmt;
			arm <= (cmt || cmt_d) ? 1'b0 : (dac_load_o ? 1'b1 : arm);
			gap <= dac_load_o ? 16'h0001 : gap + 16'h0001;
		end
	end
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ackp; ack_o |=> !ack_o; endproperty
	a_ackp: assert property (p_ackp) else $error("ack too long");
	property p_ldp; dac_load_o && !cmt_d |=> !dac_load_o; endproperty
	a_ldp: assert property (p_ldp) else $error("load too long");
	property p_cl; cmt |=> ##1 (dac_load_o || !dac_en_o); endproperty
	a_cl: assert property (p_cl) else $error("no load after setup");
	property p_rst; $past(rst_i) |-> !dac_en_o && !ack_o && !dac_load_o && dac_amp_o == 12'h000; endproperty
	a_rst: assert property (p_rst) else $error("reset left output on");
	property p_en; dac_en_o == (wv != 3'h0 && wv != 3'h7); endproperty
	a_en: assert property (p_en) else $error("enable wrong for wave");
	property p_dc; wv == 3'h1 && !dac_load_o && !cmt_d |=> $stable(dac_amp_o) && $stable(dac_ofs_o); endproperty
	a_dc: assert property (p_dc) else $error("level moved");
	property p_gap; dac_load_o && arm && wv >= 3'h2 && wv <= 3'h6 |-> gap == len[15:0]; endproperty
	a_gap: assert property (p_gap) else $error("step length wrong");
endmodule
`default_nettype wire

// *** awos_dac_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module awos_dac_model (
	input wire logic        clk_i,
	input wire logic [11:0] amp_i,
	input wire logic [11:0] ofs_i,
	input wire logic        en_i,
	input wire logic        load_i,
	output var int          lvl_o,
	output var logic        band_o
);
	// Level in units of 0.1 mV
	initial begin
		lvl_o = 0;
		band_o = 1'b0;
	end
	always @(posedge clk_i) begin
		if (load_i)
			lvl_o <= amp_i * 24 - ofs_i * 12;
		if (en_i && (lvl_o >= 30000 || lvl_o <= -30000))
			band_o <= 1'b1;
	end
endmodule
`default_nettype wire

// *** tb_awos_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_awos_sequencer;
	localparam MS_CYCLES = 64;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [4:0]  adr_i = 5'h00;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	wire  [31:0] dat_o;
	wire         ack_o;
	wire         dac_en_o;
	wire         dac_load_o;
	wire  [11:0] dac_amp_o;
	wire  [11:0] dac_ofs_o;
	int          lvl;
	logic        band;
	int          num_errors = 0;
	int          n_tests = 0;
	logic [31:0] rd;
	logic [2:0]  rw [8] = '{1, 2, 3, 4, 5, 6, 0, 7};
	logic [11:0] ra [8] = '{1023, 2048, 1023, 2048, 1000, 1, 0, 5};
	logic [11:0] ro [8] = '{0, 2048, 0, 2048, 500, 1536, 0, 0};
	logic [11:0] re [8] = '{1023, 64, 1023, 128, 1000, 768, 0, 0};
	awos_sequencer #(.MS_CYCLES(MS_CYCLES)) awos_sequencer_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.dac_amp_o(dac_amp_o), .dac_ofs_o(dac_ofs_o), .dac_en_o(dac_en_o), .dac_load_o(dac_load_o));
	awos_dac_model awos_dac_model_i (.clk_i(clk_i), .amp_i(dac_amp_o), .ofs_i(dac_ofs_o),
		.en_i(dac_en_o), .load_i(dac_load_o), .lvl_o(lvl), .band_o(band));
	initial forever #5 clk_i = ~clk_i;
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wb(logic w, logic [4:0] a, logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 50);
		if (t >= 50)
			chk("ack", 0, 1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic stp(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic setup(logic [2:0] w, logic [11:0] a, logic [11:0] o, logic [10:0] p);
		wb(1, 5'h00, w);
		wb(1, 5'h04, a);
		wb(1, 5'h08, o);
		wb(1, 5'h0c, p);
		wb(1, 5'h10, 1);
		stp(1);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 5'h0c, 0);
		chk("per", rd, 5);
		wb(0, 5'h1c, 0);
		chk("unmapped", rd, 0);
		for (int i = 0; i < 8; i++) begin
			setup(rw[i], ra[i], ro[i], 5);
			chk("en", dac_en_o, rw[i] != 0 && rw[i] != 7);
			chk("amp", dac_amp_o, re[i]);
			chk("ofs", dac_ofs_o, ro[i]);
			chk("load", dac_load_o, 1);
		end
		// Period 3 runs as 5
		setup(2, 2048, 2048, 3);
		stp(10);
		chk("up1", dac_amp_o, 128);
		stp(300);
		chk("up31", dac_amp_o, 2048);
		stp(10);
		chk("wrap", dac_amp_o, 64);
		wb(0, 5'h14, 0);
		chk("stat", rd & 32'h71, 32'h21);
		setup(4, 2048, 2048, 5);
		stp(150);
		chk("tri15", dac_amp_o, 2048);
		stp(10);
		chk("tri16", dac_amp_o, 1920);
		setup(5, 1000, 500, 5);
		stp(159);
		chk("sq0", dac_amp_o, 1000);
		stp(1);
		chk("sq1", dac_amp_o, 0);
		setup(1, 1023, 1023, 0);
		stp(2);
		chk("lvl", lvl, 12276);
		stp(50);
		chk("dc", dac_amp_o, 1023);
		setup(6, 1, 1536, 5);
		stp(85);
		chk("sine pk", dac_amp_o, 1530);
		stp(160);
		chk("sine tr", dac_amp_o, 6);
		setup(2, 2048, 2048, 5);
		stp(15);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		stp(1);
		chk("rst en", dac_en_o, 0);
		chk("rst amp", dac_amp_o, 0);
		chk("band", band, 0);
		summarize();
	end
endmodule
bind awos_sequencer awos_chk #(.MS_CYCLES(MS_CYCLES)) awos_chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.dac_amp_o(dac_amp_o), .dac_ofs_o(dac_ofs_o), .dac_en_o(dac_en_o), .dac_load_o(dac_load_o));
`default_nettype wire
